/* File: logic/wtc_pkg.sv */
package wtc_pkg;

    // Default weight width in bits, two's complement
    localparam int WTC_WGT_W = 24;
    // Percentage tolerances are whole percent of target
    localparam int WTC_PCT_DIVISOR = 100;
    // Cycles from record capture until the limits are usable
    localparam int WTC_SETTLE_CYCLES = 1;
    localparam int WTC_SETTLE_CNT_W = 2;

    // Reset values
    localparam logic WTC_RST_OUT = 1'b0;
    localparam logic WTC_RST_MOTION_EN = 1'b0;

    typedef enum logic [0:0] {
        WTC_MODE_FILL,
        WTC_MODE_OVUN
    } wtc_mode_e;

    typedef enum logic [1:0] {
        WTC_SRC_NET,
        WTC_SRC_GROSS,
        WTC_SRC_PARAM
    } wtc_src_e;

    typedef enum logic [1:0] {
        WTC_TOL_EXACT,
        WTC_TOL_DEV,
        WTC_TOL_PCT
    } wtc_tol_e;

    typedef enum logic [1:0] {
        WTC_CLS_UNDER,
        WTC_CLS_OK,
        WTC_CLS_OVER
    } wtc_class_e;

    typedef enum logic [1:0] {
        WTC_ST_EMPTY,
        WTC_ST_SETTLE,
        WTC_ST_RUN
    } wtc_state_e;

endpackage

/* File: logic/wtc_limit_calc.sv */
`timescale 1ns/1ps

module wtc_limit_calc #(
    parameter int W = wtc_pkg::WTC_WGT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wtc_pkg::wtc_tol_e tol_type_i,
    input wire logic signed [W-1:0] target_i,
    input wire logic signed [W-1:0] tol_pos_i,
    input wire logic signed [W-1:0] tol_neg_i,
    input wire logic signed [W-1:0] limit_hi_i,
    input wire logic signed [W-1:0] limit_lo_i,
    output logic signed [W+1:0] upper_o,
    output logic signed [W+1:0] lower_o
);
    import wtc_pkg::*;

    localparam int EW = 2 * W + 2;
    localparam logic signed [EW-1:0] DIV = EW'(WTC_PCT_DIVISOR);

    logic signed [EW-1:0] t_ext;
    logic signed [EW-1:0] p_ext;
    logic signed [EW-1:0] n_ext;
    logic signed [EW-1:0] hi_ext;
    logic signed [EW-1:0] lo_ext;
    logic signed [EW-1:0] sum_hi;
    logic signed [EW-1:0] sum_lo;
    logic signed [W+1:0] next_upper;
    logic signed [W+1:0] next_lower;

    assign t_ext = {{(EW-W){target_i[W-1]}}, target_i};
    assign p_ext = {{(EW-W){tol_pos_i[W-1]}}, tol_pos_i};
    assign n_ext = {{(EW-W){tol_neg_i[W-1]}}, tol_neg_i};
    assign hi_ext = {{(EW-W){limit_hi_i[W-1]}}, limit_hi_i};
    assign lo_ext = {{(EW-W){limit_lo_i[W-1]}}, limit_lo_i};

    always_comb begin
        sum_hi = hi_ext;
        sum_lo = lo_ext;
        case (tol_type_i)
            WTC_TOL_EXACT: begin
                sum_hi = hi_ext; // RULE_04
                sum_lo = lo_ext; // RULE_05
            end
            WTC_TOL_DEV: begin
                // Fixed weights, never rescaled by the target
                sum_hi = t_ext + p_ext; // RULE_06 RULE_11
                sum_lo = t_ext - n_ext; // RULE_06 RULE_11
            end
            WTC_TOL_PCT: begin
                // Truncating divide; band rounds toward the target
                sum_hi = t_ext + (t_ext * p_ext) / DIV; // RULE_07
                sum_lo = t_ext - (t_ext * n_ext) / DIV; // RULE_07
            end
            default: begin
                sum_hi = hi_ext;
                sum_lo = lo_ext;
            end
        endcase
        next_upper = sum_hi[W+1:0];
        next_lower = sum_lo[W+1:0];
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            upper_o <= '0;
            lower_o <= '0;
        end else begin
            upper_o <= next_upper;
            lower_o <= next_lower;
        end
    end

endmodule // wtc_limit_calc

/* File: logic/wtc_classifier.sv */
`timescale 1ns/1ps

// Contract
// RULE_01 - A loaded record is checked continuously, with no start command.
// RULE_02 - Filling: a magnitude inside the inclusive band is in-tolerance.
// RULE_03 - Filling: a magnitude above the upper limit is over only.
// RULE_04 - Exact: above the upper limit is over; the limit itself is OK.
// RULE_05 - Exact: below the lower limit is under; the limit itself is OK.
// RULE_06 - Deviation: above target+pos is over, below target-neg is under.
// RULE_07 - Percent: limits are target +/- tolerance times target over 100.
// RULE_08 - Motion check on: outputs update only while no motion is seen.
// RULE_09 - Motion check off: outputs follow the live result even in motion.
// RULE_10 - Each record picks net, gross or a parameter value as the weight.
// RULE_11 - Deviation tolerances are fixed weights, not scaled by the target.
// RULE_12 - Exactly one class output is high while a result is shown.
module wtc_classifier #(
    parameter int W = wtc_pkg::WTC_WGT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic clear_i,
    input wire wtc_pkg::wtc_mode_e mode_i,
    input wire wtc_pkg::wtc_src_e source_i,
    input wire wtc_pkg::wtc_tol_e tol_type_i,
    input wire logic signed [W-1:0] target_i,
    input wire logic signed [W-1:0] tol_pos_i,
    input wire logic signed [W-1:0] tol_neg_i,
    input wire logic signed [W-1:0] limit_hi_i,
    input wire logic signed [W-1:0] limit_lo_i,
    input wire logic motion_check_en_i,
    input wire logic signed [W-1:0] net_weight_i,
    input wire logic signed [W-1:0] gross_weight_i,
    input wire logic signed [W-1:0] param_weight_i,
    input wire logic no_motion_i,
    output logic under_o,
    output logic ok_o,
    output logic over_o,
    output logic result_valid_o,
    output logic loaded_o,
    output logic motion_wait_o
);
    import wtc_pkg::*;

    // Active record, captured on load
    wtc_mode_e mode;
    wtc_src_e source;
    wtc_tol_e tol_type;
    logic signed [W-1:0] target;
    logic signed [W-1:0] tol_pos;
    logic signed [W-1:0] tol_neg;
    logic signed [W-1:0] limit_hi;
    logic signed [W-1:0] limit_lo;
    wtc_mode_e next_mode;
    wtc_src_e next_source;
    wtc_tol_e next_tol_type;
    logic signed [W-1:0] next_target;
    logic signed [W-1:0] next_tol_pos;
    logic signed [W-1:0] next_tol_neg;
    logic signed [W-1:0] next_limit_hi;
    logic signed [W-1:0] next_limit_lo;

    // Sequencing
    wtc_state_e state;
    wtc_state_e next_state;
    logic [WTC_SETTLE_CNT_W-1:0] settle_cnt;
    logic [WTC_SETTLE_CNT_W-1:0] next_settle_cnt;

    // Compared weight, one register stage
    logic signed [W+1:0] weight;
    logic signed [W+1:0] next_weight;

    // Limits from the calculator
    logic signed [W+1:0] upper;
    logic signed [W+1:0] lower;

    // Live comparison and output registers
    wtc_class_e live_class;
    logic next_under;
    logic next_ok;
    logic next_over;
    logic next_valid;
    logic next_loaded;
    logic next_motion_wait;

    // Output update qualifiers
    logic run_ok;
    logic motion_hold;

    // Sign-extend, or take the magnitude when filling
    function automatic logic signed [W+1:0] widen(
        input logic signed [W-1:0] v,
        input logic mag
    );
        logic signed [W+1:0] e;
        e = {{2{v[W-1]}}, v};
        if (mag && e < 0) begin
            e = -e;
        end
        return e;
    endfunction

    // Both bounds inclusive: only strict crossings leave the OK band
    function automatic wtc_class_e classify(
        input logic signed [W+1:0] w,
        input logic signed [W+1:0] hi,
        input logic signed [W+1:0] lo
    );
        if (w > hi) begin
            return WTC_CLS_OVER;
        end else if (w < lo) begin
            return WTC_CLS_UNDER;
        end
        return WTC_CLS_OK;
    endfunction

    // Limits are registered: a new record needs one settling cycle
    wtc_limit_calc #(
        .W(W)
    ) u_limits (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tol_type_i(tol_type),
        .target_i(target),
        .tol_pos_i(tol_pos),
        .tol_neg_i(tol_neg),
        .limit_hi_i(limit_hi),
        .limit_lo_i(limit_lo),
        .upper_o(upper),
        .lower_o(lower)
    );

    // Record capture
    // Motion check enable stays live, outside the record
    always_comb begin
        next_mode = mode;
        next_source = source;
        next_tol_type = tol_type;
        next_target = target;
        next_tol_pos = tol_pos;
        next_tol_neg = tol_neg;
        next_limit_hi = limit_hi;
        next_limit_lo = limit_lo;
        if (load_i) begin
            next_mode = mode_i;
            next_source = source_i;
            next_tol_type = tol_type_i;
            next_target = target_i;
            next_tol_pos = tol_pos_i;
            next_tol_neg = tol_neg_i;
            next_limit_hi = limit_hi_i;
            next_limit_lo = limit_lo_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= WTC_MODE_FILL;
            source <= WTC_SRC_NET;
            tol_type <= WTC_TOL_EXACT;
            target <= '0;
            tol_pos <= '0;
            tol_neg <= '0;
            limit_hi <= '0;
            limit_lo <= '0;
        end else begin
            mode <= next_mode;
            source <= next_source;
            tol_type <= next_tol_type;
            target <= next_target;
            tol_pos <= next_tol_pos;
            tol_neg <= next_tol_neg;
            limit_hi <= next_limit_hi;
            limit_lo <= next_limit_lo;
        end
    end

    // Weight source select, sampled every cycle
    always_comb begin
        case (source)
            WTC_SRC_NET:
                next_weight = widen(net_weight_i,
                                    mode == WTC_MODE_FILL); // RULE_10
            WTC_SRC_GROSS:
                next_weight = widen(gross_weight_i,
                                    mode == WTC_MODE_FILL); // RULE_10
            WTC_SRC_PARAM:
                next_weight = widen(param_weight_i,
                                    mode == WTC_MODE_FILL); // RULE_10
            // Spare code reads as net weight
            default:
                next_weight = widen(net_weight_i,
                                    mode == WTC_MODE_FILL);
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            weight <= '0;
        end else begin
            weight <= next_weight;
        end
    end

    // Load takes priority over clear; a new record restarts settling
    // Settling covers the registered limits
    always_comb begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        case (state)
            WTC_ST_EMPTY: begin
                next_settle_cnt = '0;
            end
            WTC_ST_SETTLE: begin
                if (settle_cnt ==
                    WTC_SETTLE_CNT_W'(WTC_SETTLE_CYCLES - 1)) begin
                    next_state = WTC_ST_RUN; // RULE_01
                    next_settle_cnt = '0;
                end else begin
                    next_settle_cnt = settle_cnt + 1'b1;
                end
            end
            WTC_ST_RUN: begin
                // Held until a new record or a clear
                next_settle_cnt = '0;
            end
            default: begin
                next_state = WTC_ST_EMPTY;
                next_settle_cnt = '0;
            end
        endcase
        if (load_i) begin
            next_state = WTC_ST_SETTLE;
            next_settle_cnt = '0;
        end else if (clear_i) begin
            next_state = WTC_ST_EMPTY;
            next_settle_cnt = '0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= WTC_ST_EMPTY;
            settle_cnt <= '0;
        end else begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
        end
    end

    assign live_class = classify(weight, upper, lower); // RULE_02 RULE_03

    // A record change blanks the outputs at the same edge
    assign run_ok = (state == WTC_ST_RUN) && !load_i && !clear_i;
    assign motion_hold = motion_check_en_i && !no_motion_i; // RULE_08

    // Discrete outputs; a held result stays one-hot while in motion
    always_comb begin
        next_under = under_o;
        next_ok = ok_o;
        next_over = over_o;
        next_valid = result_valid_o;
        next_loaded = (next_state != WTC_ST_EMPTY);
        next_motion_wait = 1'b0;
        if (run_ok) begin
            if (motion_hold) begin
                next_motion_wait = 1'b1; // RULE_08
            end else begin
                // Live result whenever the update is not withheld
                next_under = (live_class == WTC_CLS_UNDER); // RULE_12
                next_ok = (live_class == WTC_CLS_OK); // RULE_12
                next_over = (live_class == WTC_CLS_OVER); // RULE_12
                next_valid = 1'b1; // RULE_09
            end
        end else begin
            // Stale result must not survive a record change
            next_under = WTC_RST_OUT;
            next_ok = WTC_RST_OUT;
            next_over = WTC_RST_OUT;
            next_valid = 1'b0;
        end
    end

    // Registered so lamps and reject gates never see a glitch
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            under_o <= WTC_RST_OUT;
            ok_o <= WTC_RST_OUT;
            over_o <= WTC_RST_OUT;
            result_valid_o <= 1'b0;
            loaded_o <= 1'b0;
            motion_wait_o <= 1'b0;
        end else begin
            under_o <= next_under;
            ok_o <= next_ok;
            over_o <= next_over;
            result_valid_o <= next_valid;
            loaded_o <= next_loaded;
            motion_wait_o <= next_motion_wait;
        end
    end

endmodule // wtc_classifier

/* File: test/wtc_classifier_checker.sv */
`timescale 1ns/1ps
module wtc_classifier_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic clear_i,
    input wire logic motion_check_en_i,
    input wire logic no_motion_i,
    input wire logic under_o,
    input wire logic ok_o,
    input wire logic over_o,
    input wire logic result_valid_o,
    input wire logic loaded_o,
    input wire logic motion_wait_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence blank_s;
        !result_valid_o && !under_o && !ok_o && !over_o;
    endsequence

    // Update withheld: result shown, motion check on, motion seen, no record change
    sequence held_s;
        motion_check_en_i && !no_motion_i && result_valid_o &&
            !load_i && !clear_i;
    endsequence

    one_hot_a:
        assert property (result_valid_o |-> $onehot({under_o, ok_o, over_o}))
        else $error("class outputs not one-hot");
    quiet_idle_a:
        assert property (!result_valid_o |-> !under_o && !ok_o && !over_o)
        else $error("class output high without a result");
    valid_loaded_a:
        assert property (result_valid_o |-> loaded_o)
        else $error("result shown without a record");
    load_blank_a:
        assert property (load_i |=> (loaded_o ##0 blank_s) ##1 blank_s)
        else $error("outputs not blank after record load");
    first_result_a:
        assert property (load_i && !motion_check_en_i ##1
            (!load_i && !clear_i && !motion_check_en_i) [*2]
            |=> result_valid_o)
        else $error("no result two cycles after load");
    clear_a:
        assert property (clear_i && !load_i |=> !loaded_o ##0 blank_s)
        else $error("clear did not drop the record");
    motion_hold_a:
        assert property (held_s |=> $stable({under_o, ok_o, over_o}))
        else $error("outputs changed during motion");
    motion_flag_a:
        assert property (held_s |=> motion_wait_o)
        else $error("withheld update not flagged");
    live_flag_a:
        assert property (!motion_check_en_i |=> !motion_wait_o)
        else $error("update withheld with motion check off");
endmodule // wtc_classifier_checker

bind wtc_classifier wtc_classifier_checker i_chk (
    .clk_i, .rst_i, .load_i, .clear_i, .motion_check_en_i, .no_motion_i,
    .under_o, .ok_o, .over_o, .result_valid_o, .loaded_o, .motion_wait_o
);

/* File: test/wtc_lamp_model.sv */
`timescale 1ns/1ps
module wtc_lamp_model (
    input wire logic under_i,
    input wire logic ok_i,
    input wire logic over_i,
    output wtc_pkg::wtc_class_e lamp_o,
    output logic one_lit_o
);
    import wtc_pkg::*;
    // Lamp stack: two lamps lit at once reads as no valid indication
    assign one_lit_o = $onehot({under_i, ok_i, over_i});
    assign lamp_o = over_i ? WTC_CLS_OVER : (ok_i ? WTC_CLS_OK : WTC_CLS_UNDER);
endmodule // wtc_lamp_model

/* File: test/weight_tolerance_classifier_test.sv */
`timescale 1ns/1ps
module weight_tolerance_classifier_test;
    import wtc_pkg::*;
    localparam int W = WTC_WGT_W;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic load_i = 1'b0;
    logic clear_i = 1'b0;
    logic motion_check_en_i = 1'b0;
    logic no_motion_i = 1'b1;
    wtc_mode_e mode_i = WTC_MODE_FILL;
    wtc_src_e source_i = WTC_SRC_NET;
    wtc_tol_e tol_type_i = WTC_TOL_EXACT;
    logic signed [W-1:0] target_i = '0, tol_pos_i = '0, tol_neg_i = '0;
    logic signed [W-1:0] limit_hi_i = '0, limit_lo_i = '0;
    logic signed [W-1:0] net_weight_i = '0, gross_weight_i = '0;
    logic signed [W-1:0] param_weight_i = '0;
    logic under_o, ok_o, over_o, result_valid_o, loaded_o, motion_wait_o;
    wtc_class_e lamp;
    logic one_lit;
    int n_mismatch = 0;
    int samples_checked = 0;

    wtc_classifier #(.W(W)) i_dut (
        .clk_i, .rst_i, .load_i, .clear_i, .mode_i, .source_i, .tol_type_i,
        .target_i, .tol_pos_i, .tol_neg_i, .limit_hi_i, .limit_lo_i,
        .motion_check_en_i, .net_weight_i, .gross_weight_i, .param_weight_i,
        .no_motion_i, .under_o, .ok_o, .over_o, .result_valid_o, .loaded_o,
        .motion_wait_o
    );
    wtc_lamp_model i_lamp (
        .under_i(under_o), .ok_i(ok_o), .over_i(over_o),
        .lamp_o(lamp), .one_lit_o(one_lit)
    );

    always #12.5 clk_i = ~clk_i;

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_bit(string name, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic cmp_cls(wtc_class_e exp);
        samples_checked++;
        if (lamp !== exp || one_lit !== 1'b1 || result_valid_o !== 1'b1) begin
            n_mismatch++;
            $display("FAIL class expected %0d seen %0d", exp, lamp);
        end
    endtask

    task automatic load(wtc_mode_e m, wtc_src_e s, wtc_tol_e t,
                        int tg, int tp, int tn, int hi, int lo);
        mode_i = m;
        source_i = s;
        tol_type_i = t;
        target_i = W'(tg);
        tol_pos_i = W'(tp);
        tol_neg_i = W'(tn);
        limit_hi_i = W'(hi);
        limit_lo_i = W'(lo);
        load_i = 1'b1;
        tick();
        load_i = 1'b0;
        cmp_bit("loaded", 1'b1, loaded_o);
        cmp_bit("valid", 1'b0, result_valid_o);
    endtask

    // Unselected sources get a decoy 500 counts above the sample
    task automatic chk(int w, wtc_class_e exp);
        net_weight_i = W'(source_i == WTC_SRC_NET ? w : w + 500);
        gross_weight_i = W'(source_i == WTC_SRC_GROSS ? w : w + 500);
        param_weight_i = W'(source_i == WTC_SRC_PARAM ? w : w + 500);
        tick();
        tick();
        cmp_cls(exp);
    endtask

    initial begin
        #50000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        #1 rst_i = 1'b0;
        load(WTC_MODE_OVUN, WTC_SRC_NET, WTC_TOL_EXACT,
             0, 0, 0, 100, 50);
        chk(101, WTC_CLS_OVER);
        chk(100, WTC_CLS_OK);
        chk(50, WTC_CLS_OK);
        chk(49, WTC_CLS_UNDER);
        load(WTC_MODE_OVUN, WTC_SRC_GROSS, WTC_TOL_DEV,
             100, 5, 2, 0, 0);
        chk(106, WTC_CLS_OVER);
        chk(105, WTC_CLS_OK);
        chk(98, WTC_CLS_OK);
        chk(97, WTC_CLS_UNDER);
        load(WTC_MODE_OVUN, WTC_SRC_PARAM, WTC_TOL_DEV,
             200, 5, 2, 0, 0);
        chk(206, WTC_CLS_OVER);
        chk(205, WTC_CLS_OK);
        chk(197, WTC_CLS_UNDER);
        load(WTC_MODE_OVUN, WTC_SRC_NET, WTC_TOL_PCT,
             200, 5, 2, 0, 0);
        chk(211, WTC_CLS_OVER);
        chk(210, WTC_CLS_OK);
        chk(196, WTC_CLS_OK);
        chk(195, WTC_CLS_UNDER);
        load(WTC_MODE_FILL, WTC_SRC_GROSS, WTC_TOL_DEV,
             100, 5, 2, 0, 0);
        chk(-103, WTC_CLS_OK);
        chk(-106, WTC_CLS_OVER);
        chk(-97, WTC_CLS_UNDER);
        motion_check_en_i = 1'b1;
        no_motion_i = 1'b0;
        chk(-100, WTC_CLS_UNDER);
        cmp_bit("motion_wait", 1'b1, motion_wait_o);
        no_motion_i = 1'b1;
        chk(-100, WTC_CLS_OK);
        motion_check_en_i = 1'b0;
        no_motion_i = 1'b0;
        chk(-110, WTC_CLS_OVER);
        cmp_bit("motion_wait", 1'b0, motion_wait_o);
        clear_i = 1'b1;
        tick();
        clear_i = 1'b0;
        cmp_bit("loaded", 1'b0, loaded_o);
        cmp_bit("lamp", 1'b0, under_o | ok_o | over_o);
        // Mid-run reset, then a record right after release
        load(WTC_MODE_OVUN, WTC_SRC_NET, WTC_TOL_EXACT,
             0, 0, 0, 100, 50);
        chk(75, WTC_CLS_OK);
        rst_i = 1'b1;
        tick();
        cmp_bit("loaded", 1'b0, loaded_o);
        cmp_bit("valid", 1'b0, result_valid_o);
        cmp_bit("lamp", 1'b0, under_o | ok_o | over_o);
        rst_i = 1'b0;
        load(WTC_MODE_OVUN, WTC_SRC_NET, WTC_TOL_EXACT,
             0, 0, 0, 100, 50);
        chk(40, WTC_CLS_UNDER);
        print_verdict();
    end
endmodule // weight_tolerance_classifier_test
